/* File: hw/mbf_server.sv */
`timescale 1ns/1ps
// Contract
// - header, then function code, then data
// - header is seven bytes long
// - response echoes request transaction id
// - protocol id zero, others dropped
// - length counts unit id, code, data
// - response echoes request unit id
// - unit id routes to end units
// - function code eight bits, 1 to 255
// - success echoes function code unchanged
// - error sets function code top bit
// - error data holds exception code
// - success data holds requested data
// - receiver finds message end by count
// - data is whole bytes 00 to FF
// - empty data field is accepted
// - client requests, server answers each
// - request data drives the action
module mbf_server
  import mbf_pkg::*;
(
  // clock and control
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic        i_ce,
  // request bytes from the tcp stack
  input  wire logic [7:0]  i_rx_data,
  input  wire logic        i_rx_valid,
  output logic             o_rx_ready,
  // response bytes to the tcp stack
  output logic      [7:0]  o_tx_data,
  output logic             o_tx_valid,
  output logic             o_tx_last,
  input  wire logic        i_tx_ready,
  // indication to the application
  output logic             o_ind_valid,
  output logic      [7:0]  o_ind_fc,
  output logic      [7:0]  o_ind_uid,
  output logic      [7:0]  o_ind_cnt,
  output logic             o_frame_drop,
  // shared data buffer
  input  wire logic [7:0]  i_buf_addr,
  input  wire logic        i_buf_we,
  input  wire logic [7:0]  i_buf_wdata,
  output logic      [7:0]  o_buf_rdata,
  // response from the application
  input  wire logic        i_rsp_valid,
  input  wire logic        i_rsp_err,
  input  wire logic [7:0]  i_rsp_exc,
  input  wire logic [7:0]  i_rsp_cnt
);
  mbf_strm_if #(.W(BYTE_W)) rx ();

  mbf_state_t  state_r;      // frame state
  logic [15:0] cnt_r;        // header index, then bytes left
  logic [7:0]  wr_idx_r;     // data bytes stored
  logic [7:0]  uid_r;        // unit id of the request
  logic [7:0]  fc_r;         // function code of the request
  logic        fc_bad_r;     // code zero seen
  logic        err_r;        // response is an exception
  logic [7:0]  exc_r;        // exception code
  logic [7:0]  rsp_cnt_r;    // response data bytes
  logic [8:0]  tx_pos_r;     // next response byte to load
  logic [8:0]  tx_idx_r;     // index of byte on the output
  logic [7:0]  tx_data_r;
  logic        tx_valid_r;
  logic        tx_last_r;
  logic        drop_r;
  logic [7:0]  rdata_r;
  logic [7:0]  buf_mem [256]; // request data, then response data
  logic [15:0] tid_v;
  logic [15:0] pid_v;
  logic [15:0] len_v;

  // input fifo stalls the stack while a response is pending
  mbf_fifo #(.W(BYTE_W), .D(FIFO_DEPTH)) u_fifo (
    .i_clk      (i_clk),
    .i_reset    (i_reset),
    .i_ce       (i_ce),
    .i_in_data  (i_rx_data),
    .i_in_valid (i_rx_valid),
    .o_in_ready (o_rx_ready),
    .out        (rx)
  );

  // state decode
  wire st_hdr  = state_r == ST_HDR;
  wire st_data = state_r == ST_DATA;
  wire st_skip = state_r == ST_SKIP;
  wire st_ind  = state_r == ST_IND;
  wire st_tx   = state_r == ST_TX;
  assign rx.ready = i_ce & (st_hdr | st_data | st_skip);
  wire take   = rx.valid & rx.ready;
  wire [7:0] rx_byte = rx.data;
  wire hdr_tk = take & st_hdr;
  // the function code closes the fixed part of the frame
  wire hdr_done = hdr_tk & (cnt_r == IDX_FC);
  wire fc_zero  = rx_byte == FC_INVALID;
  // foreign protocol or impossible length is not answered
  wire pid_bad  = pid_v != PROTO_ID;
  wire len_bad  = (len_v < LEN_MIN) | (len_v > LEN_MAX);
  wire hdr_bad  = pid_bad | len_bad;
  wire [15:0] data_rem = len_v - LEN_MIN;
  wire can_skip = len_v > LEN_MIN;
  wire last_in  = cnt_r == 16'h0001;
  wire rsp_take = st_ind & i_rsp_valid & i_ce;

  // field capture, high byte first
  mbf_be16 u_tid (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_ce    (i_ce),
    .i_hi_we (hdr_tk & (cnt_r == IDX_TID_HI)),
    .i_lo_we (hdr_tk & (cnt_r == IDX_TID_LO)),
    .i_byte  (rx_byte),
    .o_value (tid_v)
  );
  mbf_be16 u_pid (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_ce    (i_ce),
    .i_hi_we (hdr_tk & (cnt_r == IDX_PID_HI)),
    .i_lo_we (hdr_tk & (cnt_r == IDX_PID_LO)),
    .i_byte  (rx_byte),
    .o_value (pid_v)
  );
  mbf_be16 u_len (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_ce    (i_ce),
    .i_hi_we (hdr_tk & (cnt_r == IDX_LEN_HI)),
    .i_lo_we (hdr_tk & (cnt_r == IDX_LEN_LO)),
    .i_byte  (rx_byte),
    .o_value (len_v)
  );

  // response fields
  wire [7:0]  rsp_fc   = err_r ? (fc_r | FC_ERR_BIT) : fc_r;
  wire [7:0]  rsp_dcnt = err_r ? 8'h01 : rsp_cnt_r;
  wire [15:0] rsp_len  = LEN_MIN + {8'h00, rsp_dcnt};
  wire [8:0]  tx_total = TX_HDR_CNT + {1'b0, rsp_dcnt};
  wire [7:0]  tx_dbyte = err_r ? exc_r
                       : buf_mem[8'(tx_pos_r - TX_HDR_CNT)];
  wire [15:0] tx_pos16 = {7'h00, tx_pos_r};
  // byte select by position
  wire [7:0]  tx_byte  =
      tx_pos16 == IDX_TID_HI ? tid_v[15:8] :
      tx_pos16 == IDX_TID_LO ? tid_v[7:0]  :
      tx_pos16 == IDX_PID_HI ? PROTO_ID[15:8] :
      tx_pos16 == IDX_PID_LO ? PROTO_ID[7:0]  :
      tx_pos16 == IDX_LEN_HI ? rsp_len[15:8]  :
      tx_pos16 == IDX_LEN_LO ? rsp_len[7:0]   :
      tx_pos16 == IDX_UID    ? uid_r          :
      tx_pos16 == IDX_FC     ? rsp_fc : tx_dbyte;
  wire tx_adv  = i_ce & st_tx & (~tx_valid_r | i_tx_ready);
  wire tx_more = tx_pos_r != tx_total;
  // one buffer port, rx data or application writes
  wire buf_rx  = take & st_data;
  wire buf_app = st_ind & i_buf_we & i_ce;
  wire [7:0] buf_waddr = buf_rx ? wr_idx_r : i_buf_addr;
  wire [7:0] buf_wdata = buf_rx ? rx_byte : i_buf_wdata;

  // after the last request byte: answer alone or ask the application
  mbf_state_t done_st;
  assign done_st = fc_bad_r ? ST_TX : ST_IND;

  // frame state machine
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_r  <= ST_HDR;
      cnt_r    <= '0;
      wr_idx_r <= '0;
      uid_r    <= '0;
      fc_r     <= '0;
      fc_bad_r <= 1'b0;
      err_r    <= 1'b0;
      exc_r    <= '0;
      rsp_cnt_r <= '0;
      drop_r   <= 1'b0;
    end else if (i_ce) begin
      drop_r <= 1'b0;
      case (state_r)
        ST_HDR: begin
          if (hdr_tk) cnt_r <= cnt_r + 16'h0001;
          if (hdr_tk & (cnt_r == IDX_UID)) uid_r <= rx_byte;
          if (hdr_done) begin
            fc_r     <= rx_byte;
            fc_bad_r <= fc_zero;
            err_r    <= fc_zero;
            exc_r    <= EXC_ILL_FN;
            wr_idx_r <= '0;
            cnt_r    <= data_rem;
            if (hdr_bad) begin
              drop_r  <= 1'b1;
              state_r <= can_skip ? ST_SKIP : ST_HDR;
              if (!can_skip) cnt_r <= '0;
            end else if (data_rem == '0) begin
              state_r <= fc_zero ? ST_TX : ST_IND;
            end else begin
              state_r <= ST_DATA;
            end
          end
        end
        ST_DATA: begin
          if (take) begin
            wr_idx_r <= wr_idx_r + 8'h01;
            cnt_r    <= cnt_r - 16'h0001;
            if (last_in) state_r <= done_st;
          end
        end
        ST_SKIP: begin
          if (take) begin
            cnt_r <= cnt_r - 16'h0001;
            if (last_in) state_r <= ST_HDR;
          end
        end
        ST_IND: begin
          // application answers; error flag picks the response form
          if (i_rsp_valid) begin
            err_r     <= i_rsp_err;
            exc_r     <= i_rsp_exc;
            rsp_cnt_r <= i_rsp_cnt;
            state_r   <= ST_TX;
          end
        end
        ST_TX: begin
          if (tx_adv & ~tx_more) begin
            state_r <= ST_HDR;
            cnt_r   <= '0;
          end
        end
        default: state_r <= ST_HDR;
      endcase
    end
  end

  // response serializer, output held until the stack takes it
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      tx_pos_r   <= '0;
      tx_idx_r   <= '0;
      tx_data_r  <= '0;
      tx_valid_r <= 1'b0;
      tx_last_r  <= 1'b0;
    end else if (i_ce) begin
      if (!st_tx) begin
        tx_pos_r <= '0;
      end else if (tx_adv) begin
        tx_valid_r <= tx_more;
        if (tx_more) begin
          tx_data_r <= tx_byte;
          tx_idx_r  <= tx_pos_r;
          tx_last_r <= tx_pos_r == tx_total - 9'h001;
          tx_pos_r  <= tx_pos_r + 9'h001;
        end
      end
    end
  end

  // buffer storage and registered read port
  always_ff @(posedge i_clk) begin
    if (buf_rx | buf_app) buf_mem[buf_waddr] <= buf_wdata;
    if (i_ce) rdata_r <= buf_mem[i_buf_addr];
  end

  assign o_tx_data    = tx_data_r;
  assign o_tx_valid   = tx_valid_r;
  assign o_tx_last    = tx_last_r;
  assign o_ind_valid  = state_r[3];
  assign o_ind_fc     = fc_r;
  assign o_ind_uid    = uid_r;
  assign o_ind_cnt    = wr_idx_r;
  assign o_frame_drop = drop_r;
  assign o_buf_rdata  = rdata_r;

  // checks on the response stream and the indication
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  wire tx_on    = tx_valid_r;
  wire rx_phase = st_hdr | st_data;  // request still arriving
  sequence s_rsp_accept;
    rsp_take;
  endsequence
  sequence s_tx_first;
    tx_on && tx_idx_r == 9'h000;
  endsequence
  tid_echo_a: assert property (tx_on && tx_idx_r == 9'h000 |-> tx_data_r == tid_v[15:8])
    else $error("transaction id not echoed");
  pid_zero_a: assert property (tx_on && tx_idx_r == 9'h002 |-> tx_data_r == ZERO_BYTE)
    else $error("protocol id not zero");
  len_field_a: assert property (tx_on && tx_idx_r == 9'h005 |-> tx_data_r == rsp_len[7:0])
    else $error("length byte wrong");
  uid_echo_a: assert property (tx_on && tx_idx_r == 9'h006 |-> tx_data_r == uid_r)
    else $error("unit id not echoed");
  fc_echo_a: assert property (tx_on && tx_idx_r == 9'h007 && !err_r |-> tx_data_r == fc_r)
    else $error("function code changed");
  fc_err_a: assert property (tx_on && tx_idx_r == 9'h007 && err_r |-> tx_data_r[7])
    else $error("error bit not set");
  exc_data_a: assert property (tx_on && tx_idx_r == 9'h008 && err_r |-> tx_data_r == exc_r)
    else $error("exception code missing");
  tx_last_a: assert property (tx_on && tx_last_r |-> tx_idx_r == tx_total - 9'h001)
    else $error("last flag misplaced");
  rsp_start_a: assert property (s_rsp_accept |-> ##[1:2] s_tx_first)
    else $error("response did not start");
  ind_fc_a: assert property ($rose(o_ind_valid) |-> fc_r != FC_INVALID && $past(rx_phase))
    else $error("illegal code indicated");
endmodule : mbf_server

/* File: hw/mbf_pkg.sv */
package mbf_pkg;
  // byte positions inside the header plus function code, most significant first
  localparam logic [15:0] IDX_TID_HI = 16'h0000;  // transaction id, high byte
  localparam logic [15:0] IDX_TID_LO = 16'h0001;
  localparam logic [15:0] IDX_PID_HI = 16'h0002;  // protocol id
  localparam logic [15:0] IDX_PID_LO = 16'h0003;
  localparam logic [15:0] IDX_LEN_HI = 16'h0004;  // length of what follows
  localparam logic [15:0] IDX_LEN_LO = 16'h0005;
  localparam logic [15:0] IDX_UID    = 16'h0006;  // unit id
  localparam logic [15:0] IDX_FC     = 16'h0007;  // function code
  localparam logic [8:0]  TX_HDR_CNT = 9'h008;    // header plus function code bytes
  // field values
  localparam logic [15:0] PROTO_ID   = 16'h0000;  // only value that marks our traffic
  localparam logic [15:0] LEN_MIN    = 16'h0002;  // unit id plus function code
  localparam logic [15:0] LEN_MAX    = 16'h0101;  // keeps data within the buffer
  localparam logic [7:0]  FC_INVALID = 8'h00;     // only code outside the legal range
  localparam logic [7:0]  FC_ERR_BIT = 8'h80;     // forced on in an error response
  localparam logic [7:0]  EXC_ILL_FN = 8'h01;     // answer to an illegal code
  localparam logic [7:0]  ZERO_BYTE  = 8'h00;
  // sizes
  localparam int          FIFO_DEPTH = 8;
  localparam int          BYTE_W     = 8;
  localparam int          BUF_AW     = 8;
  // frame handling states
  typedef enum logic [4:0] {
    ST_HDR  = 5'b00001,  // collecting header and function code
    ST_DATA = 5'b00010,  // storing request data
    ST_SKIP = 5'b00100,  // discarding a frame with a foreign protocol id or a length above LEN_MAX
    ST_IND  = 5'b01000,  // request handed to the application
    ST_TX   = 5'b10000   // sending the response
  } mbf_state_t;
endpackage : mbf_pkg

/* File: hw/mbf_strm_if.sv */
`timescale 1ns/1ps
// byte stream between the input fifo and the framer
interface mbf_strm_if #(parameter int W = 8);
  logic [W-1:0] data;   // byte on offer
  logic         valid;  // byte present
  logic         ready;  // sink takes it
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : mbf_strm_if

/* File: hw/mbf_fifo.sv */
`timescale 1ns/1ps
module mbf_fifo
  import mbf_pkg::*;
#(
  parameter int W = 8,
  parameter int D = 8
) (
  // clock and control
  input  wire logic         i_clk,
  input  wire logic         i_reset,
  input  wire logic         i_ce,
  // fill side
  input  wire logic [W-1:0] i_in_data,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  // drain side
  mbf_strm_if.src           out
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(D);
  localparam logic [CW-1:0] ONE_CNT  = CW'(1);
  localparam logic [AW-1:0] ONE_PTR  = AW'(1);

  logic [W-1:0]  mem [D];  // storage words
  logic [AW-1:0] wr_ptr_r;  // next write slot
  logic [AW-1:0] rd_ptr_r;  // oldest word
  logic [CW-1:0] cnt_r;     // words held
  logic [CW-1:0] cnt_nxt;
  logic          ready_r;   // registered so the port comes from a flop
  wire           push = i_ce & i_in_valid & ready_r;
  wire           pop  = i_ce & out.valid & out.ready;

  // count follows both sides in the same cycle
  assign cnt_nxt = push & ~pop ? cnt_r + ONE_CNT :
                   pop & ~push ? cnt_r - ONE_CNT : cnt_r;
  assign out.data   = mem[rd_ptr_r];
  assign out.valid  = cnt_r != '0;
  assign o_in_ready = ready_r;

  // pointers and fill level
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r    <= '0;
      ready_r  <= 1'b0;
    end else if (i_ce) begin
      if (push) wr_ptr_r <= wr_ptr_r + ONE_PTR;
      if (pop) rd_ptr_r <= rd_ptr_r + ONE_PTR;
      cnt_r   <= cnt_nxt;
      ready_r <= cnt_nxt != FULL_CNT;  // back-pressure to the stack
    end
  end

  // storage needs no reset
  always_ff @(posedge i_clk) begin
    if (push) mem[wr_ptr_r] <= i_in_data;
  end
endmodule : mbf_fifo

/* File: hw/mbf_be16.sv */
`timescale 1ns/1ps
// two-byte field taken most significant byte first
module mbf_be16
  import mbf_pkg::*;
(
  // clock and control
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic        i_ce,
  // byte capture
  input  wire logic        i_hi_we,
  input  wire logic        i_lo_we,
  input  wire logic [7:0]  i_byte,
  // assembled value
  output logic      [15:0] o_value
);
  logic [15:0] val_r;  // held field
  assign o_value = val_r;

  // each half loads on its own strobe
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      val_r <= '0;
    end else if (i_ce) begin
      if (i_hi_we) val_r[15:8] <= i_byte;
      if (i_lo_we) val_r[7:0] <= i_byte;
    end
  end
endmodule : mbf_be16

/* File: dv/mbf_peer.sv */
`timescale 1ns/1ps
// remote client model: sends request bytes, takes response bytes
module mbf_peer (
  // clock and enable
  input  wire logic       i_clk,
  input  wire logic       i_ce,
  // request stream into the block
  output logic      [7:0] o_rx_data,
  output logic            o_rx_valid,
  input  wire logic       i_rx_ready,
  // response stream out of the block
  input  wire logic [7:0] i_tx_data,
  input  wire logic       i_tx_valid,
  input  wire logic       i_tx_last,
  output logic            o_tx_ready,
  // bench control
  input  wire logic       i_stall
);
  logic [7:0] req_q[$];  // bytes still to send
  logic [7:0] rsp_q[$];  // response bytes taken
  logic       lst_q[$];  // end marker of each taken byte
  logic       taken_r;   // front byte accepted at last edge
  logic [1:0] ph_r;      // stall pattern phase

  initial begin
    o_rx_data  = 8'h00;
    o_rx_valid = 1'b0;
    o_tx_ready = 1'b0;
    taken_r    = 1'b0;
    ph_r       = 2'h0;
  end

  // both handshakes are judged on the rising edge only
  always @(posedge i_clk) begin
    if (o_rx_valid && i_rx_ready && i_ce) begin
      taken_r = 1'b1;
    end
    if (i_tx_valid && o_tx_ready && i_ce) begin
      rsp_q.push_back(i_tx_data);
      lst_q.push_back(i_tx_last);
    end
  end

  // next byte goes out after the falling edge, held until taken
  always @(negedge i_clk) begin
    if (taken_r) begin
      void'(req_q.pop_front());
      taken_r = 1'b0;
    end
    if (req_q.size() != 0) begin
      o_rx_valid = 1'b1;
      o_rx_data  = req_q[0];
    end else begin
      // idle line toggles so a stale byte never looks like data
      o_rx_valid = 1'b0;
      o_rx_data  = ~o_rx_data;
    end
    ph_r       = ph_r + 2'h1;
    o_tx_ready = !i_stall || (ph_r == 2'h0);  // slow taker takes one in four
  end
endmodule : mbf_peer

/* File: dv/mbf_server_tb.sv */
`timescale 1ns/1ps
module mbf_server_tb;
  import mbf_pkg::*;
  localparam int LIMIT = 5000;  // cycles; every scenario fits well inside
  // design signals
  logic       i_clk, i_reset, i_ce;
  logic [7:0] rx_data, o_tx_data, o_ind_fc, o_ind_uid, o_ind_cnt, o_buf_rdata;
  logic       rx_valid, o_rx_ready, o_tx_valid, o_tx_last, tx_ready;
  logic       o_ind_valid, o_frame_drop, i_buf_we, i_rsp_valid, i_rsp_err, stall;
  logic [7:0] i_buf_addr, i_buf_wdata, i_rsp_exc, i_rsp_cnt;
  // bench bookkeeping
  int         failures = 0, cmp_count = 0, cyc = 0, drops = 0;
  logic       ind_seen = 1'b0;

  mbf_server dut (.i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce), .i_rx_data(rx_data),
    .i_rx_valid(rx_valid), .o_rx_ready(o_rx_ready), .o_tx_data(o_tx_data),
    .o_tx_valid(o_tx_valid), .o_tx_last(o_tx_last), .i_tx_ready(tx_ready),
    .o_ind_valid(o_ind_valid), .o_ind_fc(o_ind_fc), .o_ind_uid(o_ind_uid),
    .o_ind_cnt(o_ind_cnt), .o_frame_drop(o_frame_drop), .i_buf_addr(i_buf_addr),
    .i_buf_we(i_buf_we), .i_buf_wdata(i_buf_wdata), .o_buf_rdata(o_buf_rdata),
    .i_rsp_valid(i_rsp_valid), .i_rsp_err(i_rsp_err), .i_rsp_exc(i_rsp_exc),
    .i_rsp_cnt(i_rsp_cnt));
  mbf_peer peer (.i_clk(i_clk), .i_ce(i_ce), .o_rx_data(rx_data), .o_rx_valid(rx_valid),
    .i_rx_ready(o_rx_ready), .i_tx_data(o_tx_data), .i_tx_valid(o_tx_valid),
    .i_tx_last(o_tx_last), .o_tx_ready(tx_ready), .i_stall(stall));

  // clock
  always #5 i_clk = ~i_clk;

  // watchdog and event counters
  always @(posedge i_clk) begin
    cyc++;
    if (o_frame_drop === 1'b1) drops++;
    if (o_ind_valid === 1'b1) ind_seen = 1'b1;
    if (cyc == LIMIT) begin
      failures++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("failures=%0d comparisons=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic chk_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit

  // request frame, header high byte first, data FC,FD,FE,FF,00...
  task automatic push_req(input logic [15:0] tid, pid, len, input logic [7:0] uid, fc,
                          input int n);
    logic [63:0] h;
    h = {tid, pid, len, uid, fc};
    for (int k = 7; k >= 0; k--) peer.req_q.push_back(h[k*8+:8]);
    for (int i = 0; i < n; i++) peer.req_q.push_back(8'hFC + 8'(i));
  endtask : push_req

  // application side: check the indication, read data, answer
  task automatic serve(input logic [7:0] fc, uid, n, input logic err,
                       input logic [7:0] exc, nr);
    int k;
    k = 0;
    while (o_ind_valid !== 1'b1 && k < 400) begin
      @(negedge i_clk);
      k++;
    end
    chk_bit(o_ind_valid, 1'b1);
    chk_byte(o_ind_fc, fc);
    chk_byte(o_ind_uid, uid);
    chk_byte(o_ind_cnt, n);
    for (int i = 0; i < n; i++) begin
      i_buf_addr = 8'(i);
      @(negedge i_clk);
      chk_byte(o_buf_rdata, 8'hFC + 8'(i));
    end
    i_buf_we = 1'b1;
    for (int i = 0; i < nr; i++) begin
      i_buf_addr  = 8'(i);
      i_buf_wdata = 8'hC0 + 8'(i);
      @(negedge i_clk);
    end
    i_buf_we    = 1'b0;
    i_rsp_valid = 1'b1;
    i_rsp_err   = err;
    i_rsp_exc   = exc;
    i_rsp_cnt   = nr;
    @(negedge i_clk);
    i_rsp_valid = 1'b0;
  endtask : serve

  // wait for the whole response and compare it byte by byte
  task automatic expect_rsp(input logic [15:0] tid, input logic [7:0] uid, fc, input int n,
                            input logic err, input logic [7:0] exc);
    logic [7:0]  e[$];
    logic [15:0] len;
    int          k;
    len = 16'(n + 2);
    e = {tid[15:8], tid[7:0], 8'h00, 8'h00, len[15:8], len[7:0], uid, err ? fc | 8'h80 : fc};
    for (int i = 0; i < n; i++) e.push_back(err ? exc : 8'hC0 + 8'(i));
    k = 0;
    while (peer.rsp_q.size() < e.size() && k < 600) begin
      @(negedge i_clk);
      k++;
    end
    chk_byte(8'(peer.rsp_q.size()), 8'(e.size()));
    foreach (e[i]) begin
      if (peer.rsp_q.size() != 0) begin
        chk_byte(peer.rsp_q.pop_front(), e[i]);
        chk_bit(peer.lst_q.pop_front(), i == e.size() - 1);
      end
    end
  endtask : expect_rsp

  task automatic t_reset();
    chk_bit(o_rx_ready, 1'b0);
    chk_bit(o_tx_valid, 1'b0);
    chk_bit(o_ind_valid, 1'b0);
    i_reset = 1'b0;
    repeat (3) @(negedge i_clk);
    chk_bit(o_rx_ready, 1'b1);
  endtask : t_reset

  task automatic t_normal();
    push_req(16'h1234, 16'h0000, 16'h0006, 8'h11, 8'h03, 4);
    serve(8'h03, 8'h11, 8'h04, 1'b0, 8'h00, 8'h03);
    expect_rsp(16'h1234, 8'h11, 8'h03, 3, 1'b0, 8'h00);
  endtask : t_normal

  task automatic t_error();
    push_req(16'hABCD, 16'h0000, 16'h0003, 8'h22, 8'h10, 1);
    serve(8'h10, 8'h22, 8'h01, 1'b1, 8'h02, 8'h00);
    expect_rsp(16'hABCD, 8'h22, 8'h10, 1, 1'b1, 8'h02);
  endtask : t_error

  // code zero never reaches the application
  task automatic t_fc0();
    ind_seen = 1'b0;
    push_req(16'h0007, 16'h0000, 16'h0002, 8'h33, 8'h00, 0);
    expect_rsp(16'h0007, 8'h33, 8'h00, 1, 1'b1, 8'h01);
    chk_bit(ind_seen, 1'b0);
  endtask : t_fc0

  task automatic t_empty();
    push_req(16'hFFFF, 16'h0000, 16'h0002, 8'hFF, 8'h07, 0);
    // enable low: nothing may be taken while the block is frozen
    i_ce = 1'b0;
    repeat (6) @(negedge i_clk);
    chk_byte(8'(peer.req_q.size()), 8'h08);
    chk_bit(o_ind_valid, 1'b0);
    i_ce = 1'b1;
    serve(8'h07, 8'hFF, 8'h00, 1'b0, 8'h00, 8'h00);
    expect_rsp(16'hFFFF, 8'hFF, 8'h07, 0, 1'b0, 8'h00);
  endtask : t_empty

  // foreign protocol id is skipped by length, next frame still served
  task automatic t_drop();
    int d0;
    d0 = drops;
    push_req(16'h5555, 16'h0001, 16'h0004, 8'h44, 8'h03, 2);
    // length below two: header alone is dropped
    push_req(16'h6666, 16'h0000, 16'h0001, 8'h46, 8'h03, 0);
    push_req(16'h0102, 16'h0000, 16'h0002, 8'h45, 8'h01, 0);
    serve(8'h01, 8'h45, 8'h00, 1'b0, 8'h00, 8'h02);
    expect_rsp(16'h0102, 8'h45, 8'h01, 2, 1'b0, 8'h00);
    chk_byte(8'(drops - d0), 8'h02);
  endtask : t_drop

  // second request queued behind a pending one fills the input fifo
  task automatic t_fifo();
    int k;
    stall = 1'b1;
    push_req(16'h00A1, 16'h0000, 16'h0004, 8'h01, 8'h05, 2);
    k = 0;
    while (o_ind_valid !== 1'b1 && k < 200) begin
      @(negedge i_clk);
      k++;
    end
    push_req(16'h00A2, 16'h0000, 16'h0008, 8'h02, 8'h0F, 6);
    k = 0;
    while (o_rx_ready === 1'b1 && k < 50) begin
      @(negedge i_clk);
      k++;
    end
    // one more edge so the peer has dropped the last byte it saw taken
    @(negedge i_clk);
    chk_bit(o_rx_ready, 1'b0);
    chk_byte(8'(peer.req_q.size()), 8'h06);
    serve(8'h05, 8'h01, 8'h02, 1'b0, 8'h00, 8'h01);
    expect_rsp(16'h00A1, 8'h01, 8'h05, 1, 1'b0, 8'h00);
    serve(8'h0F, 8'h02, 8'h06, 1'b0, 8'h00, 8'h04);
    expect_rsp(16'h00A2, 8'h02, 8'h0F, 4, 1'b0, 8'h00);
    stall = 1'b0;
  endtask : t_fifo

  // main sequence
  initial begin
    i_clk       = 1'b0;
    i_reset     = 1'b1;
    i_ce        = 1'b1;
    i_buf_addr  = 8'h00;
    i_buf_we    = 1'b0;
    i_buf_wdata = 8'h00;
    i_rsp_valid = 1'b0;
    i_rsp_err   = 1'b0;
    i_rsp_exc   = 8'h00;
    i_rsp_cnt   = 8'h00;
    stall       = 1'b0;
    repeat (20) @(negedge i_clk);
    t_reset();
    t_normal();
    t_error();
    t_fc0();
    t_empty();
    t_drop();
    t_fifo();
    finish_test();
  end
endmodule : mbf_server_tb
